/* rtl/alc_params.svh */
// constants for the automatic level control block
`ifndef ALC_PARAMS_SVH
`define ALC_PARAMS_SVH

`define ADDR_MODE 5'h09
`define ADDR_CEIL 5'h0a
`define ADDR_GAIN 5'h0b
`define ADDR_ATTL 5'h0c
`define ADDR_ATTR 5'h0d

`define MODE_THR 0
`define MODE_RSTEP 1
`define MODE_LSTEP_LO 2
`define MODE_LSTEP_HI 3
`define MODE_ZCDIS 4
`define MODE_EN 5

`define RST_MODE 6'h00
`define RST_CEIL 7'h36
`define RST_GAIN 7'h10
`define RST_ATT 8'h00
`define GAIN_MIN 7'h00

`define SEL_LIM_LO 0
`define SEL_LIM_HI 1
`define SEL_WAIT_LO 2
`define SEL_WAIT_HI 3
`define SEL_ZTO_LO 4
`define SEL_ZTO_HI 5
`define RST_SEL 6'h00

`define BASE_WAIT 11'h080
`define BASE_HALF 4'h1

// magnitudes of a 16-bit sample at -4, -6 and -8 dBFS
`define LVL_M4 15'h50c3
`define LVL_M6 15'h4026
`define LVL_M8 15'h32f5

`endif

/* rtl/alc_pkg.sv */
// shared types of the automatic level control block
package alc_pkg;
   typedef logic [6:0] gain_t;
   typedef logic [10:0] count_t;
   typedef logic [15:0] sample_t;
   typedef logic [7:0] byte_t;
   typedef enum logic [1:0] {
      CH_IDLE = 2'b00,
      CH_WAIT = 2'b01
   } ch_state_t;
endpackage

/* rtl/auto_level_gain_control.sv */
// automatic level control with gain, ceiling and attenuator registers
`timescale 1ns/1ps
`include "alc_params.svh"
module auto_level_gain_control
(
   input wire logic clk,
   input wire logic nrst,
   input wire logic ce,
   input wire logic mic_path_power,
   input wire logic sample_valid,
   input wire logic fs2_tick,
   input wire alc_pkg::sample_t sample_left,
   input wire alc_pkg::sample_t sample_right,
   input wire logic [5:0] timer_select,
   input wire logic [4:0] reg_addr,
   input wire alc_pkg::byte_t reg_wdata,
   input wire logic reg_we,
   input wire logic reg_re,
   output alc_pkg::byte_t reg_rdata_ff,
   output alc_pkg::gain_t gain_left_ff,
   output alc_pkg::gain_t gain_right_ff,
   output alc_pkg::byte_t atten_left_out_ff,
   output alc_pkg::byte_t atten_right_out_ff,
   output logic mic_power_out_ff,
   input wire logic atten_gang_mode
);
   import alc_pkg::*;

   // ********************************************************
   // register file
   // ********************************************************
   logic [5:0] mode_ff;
   gain_t ceiling_ff;
   gain_t gain_wr_ff;
   byte_t att_l_ff;
   byte_t att_r_ff;
   logic [5:0] sel_ff;

   logic wr_mode;
   logic wr_ceil;
   logic wr_gain;
   logic wr_attl;
   logic wr_attr;
   byte_t rd_mux;

   assign wr_mode = reg_we && (reg_addr == `ADDR_MODE);
   assign wr_ceil = reg_we && (reg_addr == `ADDR_CEIL);
   assign wr_gain = reg_we && (reg_addr == `ADDR_GAIN);
   assign wr_attl = reg_we && (reg_addr == `ADDR_ATTL);
   assign wr_attr = reg_we && (reg_addr == `ADDR_ATTR);

   // unmapped addresses and reserved bits read as zero
   assign rd_mux = (reg_addr == `ADDR_MODE) ? {2'b00, mode_ff} :
                   (reg_addr == `ADDR_CEIL) ? {1'b0, ceiling_ff} :
                   (reg_addr == `ADDR_GAIN) ? {1'b0, gain_wr_ff} :
                   (reg_addr == `ADDR_ATTL) ? att_l_ff :
                   (reg_addr == `ADDR_ATTR) ? att_r_ff : 8'h00;

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         mode_ff <= `RST_MODE;
         ceiling_ff <= `RST_CEIL;
         gain_wr_ff <= `RST_GAIN;
         att_l_ff <= `RST_ATT;
         att_r_ff <= `RST_ATT;
         reg_rdata_ff <= 8'h00;
      end
      else if (ce)
      begin
         if (wr_mode)
            mode_ff <= reg_wdata[5:0];
         if (wr_ceil)
            ceiling_ff <= reg_wdata[6:0];
         if (wr_gain)
            gain_wr_ff <= reg_wdata[6:0];
         if (wr_attl)
            att_l_ff <= reg_wdata;
         if (wr_attr)
            att_r_ff <= reg_wdata;
         if (reg_re)
            reg_rdata_ff <= rd_mux;
      end
   end

   // ********************************************************
   // timer selection, held internally from its control port
   // ********************************************************
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         sel_ff <= `RST_SEL;
      else if (ce)
         sel_ff <= timer_select;
   end

   logic alc_en;
   logic zc_dis;
   logic thr_sel;
   logic rstep_sel;
   logic [1:0] lstep_sel;
   logic [1:0] lim_sel;
   logic [1:0] wait_sel;
   logic [1:0] zto_sel;
   count_t wait_len;
   count_t zto_len;
   logic [3:0] lim_len;

   assign alc_en = mode_ff[`MODE_EN];
   assign zc_dis = mode_ff[`MODE_ZCDIS];
   assign thr_sel = mode_ff[`MODE_THR];
   assign rstep_sel = mode_ff[`MODE_RSTEP];
   assign lstep_sel = mode_ff[`MODE_LSTEP_HI:`MODE_LSTEP_LO];
   assign lim_sel = sel_ff[`SEL_LIM_HI:`SEL_LIM_LO];
   assign wait_sel = sel_ff[`SEL_WAIT_HI:`SEL_WAIT_LO];
   assign zto_sel = sel_ff[`SEL_ZTO_HI:`SEL_ZTO_LO];
   assign wait_len = `BASE_WAIT << wait_sel;
   assign zto_len = `BASE_WAIT << zto_sel;
   assign lim_len = `BASE_HALF << lim_sel;

   // ********************************************************
   // level detection and per-channel gain gates
   // ********************************************************
   logic lim_l;
   logic lim_r;
   logic rst_l;
   logic rst_r;
   logic zc_l;
   logic zc_r;

   level_detect det_left (
      .clk(clk),
      .nrst(nrst),
      .ce(ce),
      .sample_valid(sample_valid),
      .sample(sample_left),
      .thr_sel(thr_sel),
      .over_limit_ff(lim_l),
      .over_reset_ff(rst_l),
      .zero_cross_ff(zc_l)
   );

   level_detect det_right (
      .clk(clk),
      .nrst(nrst),
      .ce(ce),
      .sample_valid(sample_valid),
      .sample(sample_right),
      .thr_sel(thr_sel),
      .over_limit_ff(lim_r),
      .over_reset_ff(rst_r),
      .zero_cross_ff(zc_r)
   );

   chan_gain_if ch_l ();
   chan_gain_if ch_r ();

   gain_t target_ff;
   logic imm_ff;

   assign ch_l.target = target_ff;
   assign ch_r.target = target_ff;
   assign ch_l.immediate = imm_ff;
   assign ch_r.immediate = imm_ff;
   assign ch_l.zc = zc_l;
   assign ch_r.zc = zc_r;
   assign ch_l.tick = sample_valid;
   assign ch_r.tick = sample_valid;
   assign ch_l.timeout = zto_len;
   assign ch_r.timeout = zto_len;
   assign ch_l.mic_on = mic_path_power;
   assign ch_r.mic_on = mic_path_power;

   chan_gain_gate gate_left (
      .clk(clk),
      .nrst(nrst),
      .ce(ce),
      .ch(ch_l.gate)
   );

   chan_gain_gate gate_right (
      .clk(clk),
      .nrst(nrst),
      .ce(ce),
      .ch(ch_r.gate)
   );

   // ********************************************************
   // limiter and recovery control
   // ********************************************************
   count_t wait_ff;
   logic [3:0] lim_cnt_ff;
   logic was_en_ff;

   logic over_limit;
   logic over_reset;
   logic settled;
   logic lim_ready;
   logic lim_fire;
   logic rec_fire;
   logic [2:0] lim_step;
   logic [1:0] rec_step;
   logic [7:0] rec_sum;
   gain_t lim_gain;
   gain_t rec_gain;

   assign over_limit = lim_l || lim_r;
   assign over_reset = rst_l || rst_r;
   assign settled = (ch_l.applied == target_ff) &&
                    (ch_r.applied == target_ff);
   // gated mode waits until both channels took the previous step
   assign lim_ready = zc_dis ? (lim_cnt_ff == 4'h0) : settled;
   assign lim_fire = alc_en && mic_path_power && over_limit &&
                     lim_ready;
   assign rec_fire = alc_en && mic_path_power && !over_reset &&
                     sample_valid && (wait_ff >= wait_len - 11'h001);
   assign lim_step = {1'b0, lstep_sel} + 3'h1;
   assign rec_step = rstep_sel ? 2'h2 : 2'h1;
   assign lim_gain = (target_ff < {4'h0, lim_step}) ? `GAIN_MIN :
                     target_ff - {4'h0, lim_step};
   assign rec_sum = {1'b0, target_ff} + {6'h00, rec_step};
   // a code already above the ceiling is left alone, never pulled down
   assign rec_gain = (target_ff >= ceiling_ff) ? target_ff :
                     (rec_sum > {1'b0, ceiling_ff}) ? ceiling_ff :
                     rec_sum[6:0];

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         target_ff <= `RST_GAIN;
         imm_ff <= 1'b0;
         wait_ff <= '0;
         lim_cnt_ff <= 4'h0;
         was_en_ff <= 1'b0;
      end
      else if (ce)
      begin
         was_en_ff <= alc_en;
         if (fs2_tick && (lim_cnt_ff != 4'h0))
            lim_cnt_ff <= lim_cnt_ff - 4'h1;
         if (!mic_path_power)
         begin
            target_ff <= `RST_GAIN;
            imm_ff <= 1'b0;
            wait_ff <= '0;
            lim_cnt_ff <= 4'h0;
         end
         else if (lim_fire)
         begin
            target_ff <= lim_gain;
            imm_ff <= zc_dis;
            wait_ff <= '0;
            lim_cnt_ff <= lim_len;
         end
         else if (alc_en)
         begin
            if (over_reset)
               wait_ff <= '0;
            else if (rec_fire)
            begin
               target_ff <= rec_gain;
               imm_ff <= 1'b0;
               wait_ff <= '0;
            end
            else if (sample_valid)
               wait_ff <= wait_ff + 11'h001;
         end
         else
         begin
            wait_ff <= '0;
            // software writes only steer the gain while control is off
            if (wr_gain)
            begin
               target_ff <= reg_wdata[6:0];
               imm_ff <= 1'b0;
            end
            else if (was_en_ff)
               imm_ff <= 1'b0;
         end
      end
   end

   // ********************************************************
   // outputs
   // ********************************************************
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         gain_left_ff <= `RST_GAIN;
         gain_right_ff <= `RST_GAIN;
         atten_left_out_ff <= `RST_ATT;
         atten_right_out_ff <= `RST_ATT;
         mic_power_out_ff <= 1'b0;
      end
      else if (ce)
      begin
         gain_left_ff <= ch_l.applied;
         gain_right_ff <= ch_r.applied;
         // one code is half a decibel downstream
         atten_left_out_ff <= att_l_ff;
         atten_right_out_ff <= atten_gang_mode ? att_l_ff :
                               att_r_ff;
         mic_power_out_ff <= mic_path_power;
      end
   end
endmodule

/* rtl/chan_gain_gate.sv */
// applies the target gain on one channel at once when immediate, else at zero cross or timeout
`timescale 1ns/1ps
`include "alc_params.svh"
module chan_gain_gate
(
   input wire logic clk,
   input wire logic nrst,
   input wire logic ce,
   chan_gain_if.gate ch
);
   import alc_pkg::*;
   ch_state_t state_ff;
   count_t cnt_ff;
   gain_t applied_ff;
   logic pending;
   logic expire;

   assign pending = ch.target != applied_ff;
   assign expire = ch.tick && (cnt_ff >= ch.timeout - 11'h001);
   assign ch.applied = applied_ff;

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         state_ff <= CH_IDLE;
         cnt_ff <= '0;
         applied_ff <= `RST_GAIN;
      end
      else if (ce)
      begin
         if (!ch.mic_on)
         begin
            state_ff <= CH_IDLE;
            cnt_ff <= '0;
            applied_ff <= `RST_GAIN;
         end
         else if (!pending)
         begin
            state_ff <= CH_IDLE;
            cnt_ff <= '0;
         end
         else if (ch.immediate || ch.zc || expire)
         begin
            applied_ff <= ch.target;
            state_ff <= CH_IDLE;
            cnt_ff <= '0;
         end
         else
         begin
            state_ff <= CH_WAIT;
            if (ch.tick)
               cnt_ff <= cnt_ff + 11'h001;
         end
      end
   end
endmodule

/* rtl/chan_gain_if.sv */
// one channel's link between the level controller and its gain gate
`timescale 1ns/1ps
interface chan_gain_if;
   import alc_pkg::*;
   gain_t target;
   logic immediate;
   logic zc;
   logic tick;
   count_t timeout;
   logic mic_on;
   gain_t applied;
   modport ctrl (output target, immediate, zc, tick, timeout, mic_on,
      input applied);
   modport gate (input target, immediate, zc, tick, timeout, mic_on,
      output applied);
endinterface

/* rtl/level_detect.sv */
// per-channel level compare and zero-cross detect on each sample
`timescale 1ns/1ps
`include "alc_params.svh"
module level_detect
(
   input wire logic clk,
   input wire logic nrst,
   input wire logic ce,
   input wire logic sample_valid,
   input wire alc_pkg::sample_t sample,
   input wire logic thr_sel,
   output logic over_limit_ff,
   output logic over_reset_ff,
   output logic zero_cross_ff
);
   import alc_pkg::*;
   logic sign_ff;
   logic [14:0] mag;
   logic [14:0] lim_lvl;
   logic [14:0] rst_lvl;

   // ones complement magnitude avoids the overflow of -32768
   assign mag = sample[15] ? ~sample[14:0] : sample[14:0];
   assign lim_lvl = thr_sel ? `LVL_M4 : `LVL_M6;
   assign rst_lvl = thr_sel ? `LVL_M6 : `LVL_M8;

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         sign_ff <= 1'b0;
         over_limit_ff <= 1'b0;
         over_reset_ff <= 1'b0;
         zero_cross_ff <= 1'b0;
      end
      else if (ce)
      begin
         zero_cross_ff <= sample_valid && (sample[15] != sign_ff);
         if (sample_valid)
         begin
            sign_ff <= sample[15];
            over_limit_ff <= mag >= lim_lvl;
            over_reset_ff <= mag >= rst_lvl;
         end
      end
   end
endmodule

/* testbench/auto_level_gain_control_monitor.sv */
// port checker for the automatic level control block
`timescale 1ns/1ps
module auto_level_gain_control_monitor
(
   input wire logic clk,
   input wire logic nrst,
   input wire logic ce,
   input wire logic mic_path_power,
   input wire logic sample_valid,
   input wire logic fs2_tick,
   input wire alc_pkg::sample_t sample_left,
   input wire alc_pkg::sample_t sample_right,
   input wire logic [5:0] timer_select,
   input wire logic [4:0] reg_addr,
   input wire alc_pkg::byte_t reg_wdata,
   input wire logic reg_we,
   input wire logic reg_re,
   input wire alc_pkg::byte_t reg_rdata_ff,
   input wire alc_pkg::gain_t gain_left_ff,
   input wire alc_pkg::gain_t gain_right_ff,
   input wire alc_pkg::byte_t atten_left_out_ff,
   input wire alc_pkg::byte_t atten_right_out_ff,
   input wire logic mic_power_out_ff,
   input wire logic atten_gang_mode
);
   import alc_pkg::*;
   // ***************
   // properties
   // ***************
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!nrst);
   sequence s_mic_off;
      (!mic_path_power && ce) [*4];
   endsequence
   sequence s_gang;
      (atten_gang_mode && ce) [*3];
   endsequence
   sequence s_rd(logic [4:0] a);
      ce && reg_re && reg_addr == a;
   endsequence
   property p_mic_off;
      s_mic_off |-> gain_left_ff == 7'h10 && gain_right_ff == 7'h10;
   endproperty
   property p_mic_copy;
      ce |=> mic_power_out_ff == $past(mic_path_power);
   endproperty
   property p_gang;
      s_gang |-> atten_right_out_ff == atten_left_out_ff;
   endproperty
   property p_unmapped;
      s_rd(5'h1f) |=> reg_rdata_ff == 8'h00;
   endproperty
   property p_rd_hold;
      !(ce && reg_re) |=> $stable(reg_rdata_ff);
   endproperty
   property p_mode_rsv;
      s_rd(5'h09) |=> reg_rdata_ff[7:6] == 2'b00;
   endproperty
   property p_seven_bit;
      ce && reg_re && (reg_addr == 5'h0a || reg_addr == 5'h0b)
         |=> !reg_rdata_ff[7];
   endproperty
   property p_freeze;
      !ce |=> $stable(gain_left_ff) && $stable(reg_rdata_ff);
   endproperty
   a_mic_off: assert property (p_mic_off)
      else $error("gain not at default with mic path off");
   a_mic_copy: assert property (p_mic_copy)
      else $error("mic power output does not follow its bit");
   a_gang: assert property (p_gang)
      else $error("ganged right attenuation differs from left");
   a_unmapped: assert property (p_unmapped)
      else $error("unmapped read not zero");
   a_rd_hold: assert property (p_rd_hold)
      else $error("read data moved without a read");
   a_mode_rsv: assert property (p_mode_rsv)
      else $error("mode register reserved bits set");
   a_seven_bit: assert property (p_seven_bit)
      else $error("gain or ceiling read with top bit set");
   a_freeze: assert property (p_freeze)
      else $error("state moved with clock enable low");
endmodule

bind auto_level_gain_control auto_level_gain_control_monitor u_mon (.*);

/* testbench/auto_level_gain_control_test.sv */
// self-checking bench for the automatic level control block
`timescale 1ns/1ps
module auto_level_gain_control_test;
   import alc_pkg::*;
   logic clk = 0, nrst = 0, ce = 1, mic = 0, sv = 0, fs2 = 0, gang = 0;
   sample_t sl = 16'h0000, sr = 16'h0000;
   logic [5:0] tsel = 6'h00;
   logic [4:0] addr = 5'h00;
   byte_t wd = 8'h00, rd, atl, atr;
   logic we = 0, re = 0, mo, rd_pend_ff = 0;
   gain_t gl, gr, g;
   byte_t a, b, exp_q[$];
   int num_errors = 0, n_tests = 0;
   always #10 clk = ~clk;
   always @(posedge clk) fs2 <= ~fs2;
   auto_level_gain_control u_auto_level_gain_control (.clk(clk),
      .nrst(nrst), .ce(ce), .mic_path_power(mic), .sample_valid(sv),
      .fs2_tick(fs2), .sample_left(sl), .sample_right(sr),
      .timer_select(tsel), .reg_addr(addr), .reg_wdata(wd), .reg_we(we),
      .reg_re(re), .reg_rdata_ff(rd), .gain_left_ff(gl),
      .gain_right_ff(gr), .atten_left_out_ff(atl),
      .atten_right_out_ff(atr), .mic_power_out_ff(mo),
      .atten_gang_mode(gang));
   // ***************
   // checking
   // ***************
   task cmp_rd(byte_t got, byte_t exp);
      n_tests++;
      if (got !== exp)
      begin
         num_errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task cmp_out(logic [7:0] got, logic [7:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         num_errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // read data is due one edge after the strobe is taken
   always @(posedge clk)
   begin
      if (rd_pend_ff)
         cmp_rd(rd, exp_q.pop_front());
      rd_pend_ff <= re;
   end
   task report_and_stop;
      $display("errors=%0d comparisons=%0d", num_errors, n_tests);
      if (num_errors == 0 && n_tests > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   // ***************
   // stimulus
   // ***************
   task wr(logic [4:0] ad, byte_t d);
      we <= 1;
      addr <= ad;
      wd <= d;
      @(posedge clk);
      we <= 0;
      @(posedge clk);
   endtask
   task rdx(logic [4:0] ad, byte_t e);
      re <= 1;
      addr <= ad;
      exp_q.push_back(e);
      @(posedge clk);
      re <= 0;
      @(posedge clk);
   endtask
   task snd(sample_t v);
      sl <= v;
      sr <= v;
      sv <= 1;
      @(posedge clk);
      sv <= 0;
      repeat (3) @(posedge clk);
   endtask
   task gains(gain_t e);
      cmp_out({1'b0, gl}, {1'b0, e});
      cmp_out({1'b0, gr}, {1'b0, e});
   endtask
   initial
   begin
      #400000;
      num_errors++;
      report_and_stop();
   end
   initial
   begin
      a = 8'($urandom(32'h6f3a));
      repeat (5) @(posedge clk);
      nrst <= 1;
      @(posedge clk);
      rdx(5'h09, 8'h00);
      rdx(5'h0a, 8'h36);
      rdx(5'h0b, 8'h10);
      rdx(5'h0c, 8'h00);
      rdx(5'h0d, 8'h00);
      rdx(5'h1f, 8'h00);
      ce <= 0;
      repeat (3) @(posedge clk);
      ce <= 1;
      a = 8'($urandom());
      b = 8'($urandom());
      wr(5'h0c, a);
      wr(5'h0d, b);
      rdx(5'h0c, a);
      rdx(5'h0d, b);
      cmp_out(atl, a);
      cmp_out(atr, b);
      gang <= 1;
      repeat (4) @(posedge clk);
      cmp_out(atr, a);
      rdx(5'h0d, b);
      mic <= 1;
      tsel <= 6'h03;
      repeat (4) @(posedge clk);
      gains(7'h10);
      cmp_out({7'h00, mo}, 8'h01);
      // zero cross off, longest spacing so one loud sample gives one step
      g = 7'h10;
      for (int i = 0; i < 6; i++)
      begin
         b = (i > 3) ? 8'h03 : 8'(i);
         wr(5'h09, 8'h30 | (b << 2));
         snd(16'h7000);
         snd(16'h0000);
         repeat (20) @(posedge clk);
         g = (g > 7'(b + 1)) ? g - 7'(b + 1) : 7'h00;
         gains(g);
      end
      wr(5'h09, 8'h00);
      repeat (8) @(posedge clk);
      gains(7'h00);
      // gain written only with control off and mic powered
      wr(5'h0b, 8'h20);
      rdx(5'h0b, 8'h20);
      gains(7'h00);
      snd(16'h0100);
      snd(16'hff00);
      gains(7'h20);
      mic <= 0;
      repeat (6) @(posedge clk);
      gains(7'h10);
      cmp_out({7'h00, mo}, 8'h00);
      mic <= 1;
      wr(5'h0a, 8'h13);
      wr(5'h09, 8'h22);
      // quiet samples of alternating sign: two recoveries, second clamps
      for (int i = 0; i < 300; i++)
         snd(i[0] ? 16'hff00 : 16'h0100);
      gains(7'h13);
      rdx(5'h0a, 8'h13);
      // raised threshold: in-band samples of both signs leave the gain
      wr(5'h09, 8'h21);
      snd(16'h4800);
      snd(16'hb800);
      gains(7'h13);
      snd(16'h0100);
      snd(16'h6000);
      gains(7'h13);
      snd(16'hff00);
      gains(7'h12);
      // no zero cross after the step: only the timeout applies it
      tsel <= 6'h07;
      snd(16'h0100);
      snd(16'h6000);
      for (int i = 0; i < 120; i++)
         snd(16'h0100);
      gains(7'h12);
      for (int i = 0; i < 20; i++)
         snd(16'h0100);
      gains(7'h11);
      report_and_stop();
   end
endmodule
